// ==== src/irq_src_pkg.sv ====
package irq_src_pkg;

    // ****************************************************************
    // sizes
    // ****************************************************************
    localparam int NUM_SRC  = 11;
    localparam int NUM_PIN  = 4;
    localparam int ADDR_W   = 5;
    localparam int DATA_W   = 16;
    localparam int LEVEL_W  = 2;
    localparam int SRC_W    = 4;
    localparam int T6_CNT_W = 16;

    // ****************************************************************
    // source numbers, also the index of each control register
    // ****************************************************************
    localparam int SRC_CAPSTAN_FG   = 0;
    localparam int SRC_TIMER0       = 1;
    localparam int SRC_TIMER1       = 2;
    localparam int SRC_TIMER2       = 3;
    localparam int SRC_TIMER3       = 4;
    localparam int SRC_TIMER4       = 5;
    localparam int SRC_TIMER6       = 6;
    localparam int SRC_CONTROL      = 7;
    localparam int SRC_HEAD_SWITCH  = 8;
    localparam int SRC_SERVO_VSYNC  = 9;
    localparam int SRC_PATTERN_GEN  = 10;

    // ****************************************************************
    // pin slots in the synchroniser
    // ****************************************************************
    localparam int PIN_CAPSTAN_FG   = 0;
    localparam int PIN_CONTROL      = 1;
    localparam int PIN_HEAD_SWITCH  = 2;
    localparam int PIN_SERVO_VSYNC  = 3;

    // ****************************************************************
    // register offsets
    // ****************************************************************
    localparam logic [ADDR_W-1:0] ADDR_CTRL_BASE = 5'h00;
    localparam logic [ADDR_W-1:0] ADDR_STATUS    = 5'h10;
    localparam logic [ADDR_W-1:0] ADDR_MASK      = 5'h11;
    localparam logic [ADDR_W-1:0] ADDR_PATTERN   = 5'h12;
    localparam logic [ADDR_W-1:0] ADDR_PRESENT   = 5'h13;

    // ****************************************************************
    // control register fields and values
    // ****************************************************************
    localparam int CTRL_LEVEL_LSB  = 0;
    localparam int CTRL_ENABLE_BIT = 2;
    localparam int CTRL_PEND_BIT   = 3;
    localparam int CTRL_T6SEL_LSB  = 4;
    localparam logic [LEVEL_W-1:0] LEVEL_MAX = 2'h2;
    localparam int T6_TOP_BIT      = 15;

    // timer 6 cause select
    localparam logic [1:0] T6_SEL_OVF16 = 2'h0;
    localparam logic [1:0] T6_SEL_CNT15 = 2'h1;
    localparam logic [1:0] T6_SEL_CNT14 = 2'h2;
    localparam logic [1:0] T6_SEL_CNT13 = 2'h3;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef struct packed {
        logic [1:0]         t6_sel;
        logic               pend;
        logic               enable;
        logic [LEVEL_W-1:0] level;
    } ctrl_type;

    typedef struct packed {
        logic [NUM_PIN-1:0] s1;
        logic [NUM_PIN-1:0] s2;
        logic [NUM_PIN-1:0] prev;
    } pin_sync_type;

    typedef struct packed {
        ctrl_type [NUM_SRC-1:0] ctrl;
        logic [NUM_SRC-1:0]     status;
        logic [NUM_SRC-1:0]     mask;
        logic [DATA_W-1:0]      pattern;
        pin_sync_type           pins;
        logic [T6_CNT_W-1:0]    t6_prev;
        logic                   spg_eq_prev;
        logic [DATA_W-1:0]      rdata;
        logic                   irq_req;
        logic [LEVEL_W-1:0]     irq_level;
        logic [SRC_W-1:0]       irq_src;
        logic                   int_out;
    } state_type;

    localparam state_type STATE_RESET = '0;

endpackage

// ==== src/maskable_irq_sources.sv ====
// Notes on behaviour
// - a pending source presents the level held in its own control register to the core.
// - software sets each level 0 to 2; the block stores and uses it.
// - a rising edge on the capstan FG pin raises the capstan request.
// - timers 0, 1, 3 and 4 raise their own request on overflow.
// - timer 2 requests on overflow, compare match, capture edge or bit counter underflow.
// - timer 6 requests on 16-bit overflow or on 2^15, 2^14 or 2^13 count.
// - any change of the tape control signal raises the control request.
// - any change of the head switch signal raises the head switch request.
// - any change of the servo vertical sync raises the servo vsync request.
// - free running counter equal to the pattern timing value raises the pattern request.
// - only enabled requests with level below the status word mask level are presented.
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

module maskable_irq_sources (
    input  wire logic                                 i_sys_clk,
    input  wire logic                                 i_rst_n,
    // register port
    input  wire logic [irq_src_pkg::ADDR_W-1:0]       i_reg_addr,
    input  wire logic [irq_src_pkg::DATA_W-1:0]       i_reg_wdata,
    input  wire logic                                 i_reg_wr,
    input  wire logic                                 i_reg_rd,
    output logic      [irq_src_pkg::DATA_W-1:0]       o_reg_rdata,
    // pins, asynchronous
    input  wire logic                                 i_capstan_fg_input,
    input  wire logic                                 i_control_signal,
    input  wire logic                                 i_head_switch_signal,
    input  wire logic                                 i_servo_vsync,
    // on-chip causes, same clock
    input  wire logic                                 i_timer0_ovf,
    input  wire logic                                 i_timer1_ovf,
    input  wire logic                                 i_timer2_ovf,
    input  wire logic                                 i_timer2_cmp_match,
    input  wire logic                                 i_timer2_capture_edge,
    input  wire logic                                 i_serial_bit_down_counter_unf,
    input  wire logic                                 i_timer3_ovf,
    input  wire logic                                 i_timer4_ovf,
    input  wire logic [irq_src_pkg::T6_CNT_W-1:0]     i_timer6_count,
    input  wire logic [irq_src_pkg::DATA_W-1:0]       i_frc_value,
    // core side
    input  wire logic [irq_src_pkg::LEVEL_W-1:0]      i_psw_mask_level,
    input  wire logic                                 i_irq_ack,
    output logic                                      o_irq_req,
    output logic      [irq_src_pkg::LEVEL_W-1:0]      o_irq_level,
    output logic      [irq_src_pkg::SRC_W-1:0]        o_irq_src,
    output logic                                      o_int
);

    // ****************************************************************
    // state
    // ****************************************************************
    irq_src_pkg::state_type              q;
    irq_src_pkg::state_type              d;
    logic [irq_src_pkg::NUM_SRC-1:0]     ev;
    logic [irq_src_pkg::T6_CNT_W-1:0]    t6_fall;
    logic                                spg_eq;
    logic                                found;
    logic [irq_src_pkg::LEVEL_W-1:0]     best_lvl;
    logic [irq_src_pkg::SRC_W-1:0]       best_src;
    logic [irq_src_pkg::LEVEL_W-1:0]     wr_level;

    // ****************************************************************
    // cause detection
    // ****************************************************************

    // timer 6 tap bits falling mark a count boundary
    assign t6_fall = q.t6_prev & ~i_timer6_count;
    assign spg_eq  = (i_frc_value == q.pattern);

    // one pulse per source event
    always_comb begin
        ev = '0;
        ev[irq_src_pkg::SRC_CAPSTAN_FG] = q.pins.s2[irq_src_pkg::PIN_CAPSTAN_FG]
                                          & ~q.pins.prev[irq_src_pkg::PIN_CAPSTAN_FG];

        ev[irq_src_pkg::SRC_TIMER0] = i_timer0_ovf;
        ev[irq_src_pkg::SRC_TIMER1] = i_timer1_ovf;
        ev[irq_src_pkg::SRC_TIMER2] = i_timer2_ovf | i_timer2_cmp_match
                                      | i_timer2_capture_edge | i_serial_bit_down_counter_unf;
        ev[irq_src_pkg::SRC_TIMER3] = i_timer3_ovf;
        ev[irq_src_pkg::SRC_TIMER4] = i_timer4_ovf;

        // select 2^16, 2^15, 2^14 or 2^13 boundary
        ev[irq_src_pkg::SRC_TIMER6] = t6_fall[irq_src_pkg::T6_TOP_BIT
                                      - int'(q.ctrl[irq_src_pkg::SRC_TIMER6].t6_sel)];

        ev[irq_src_pkg::SRC_CONTROL] = q.pins.s2[irq_src_pkg::PIN_CONTROL]
                                       ^ q.pins.prev[irq_src_pkg::PIN_CONTROL];
        ev[irq_src_pkg::SRC_HEAD_SWITCH] = q.pins.s2[irq_src_pkg::PIN_HEAD_SWITCH]
                                           ^ q.pins.prev[irq_src_pkg::PIN_HEAD_SWITCH];
        ev[irq_src_pkg::SRC_SERVO_VSYNC] = q.pins.s2[irq_src_pkg::PIN_SERVO_VSYNC]
                                           ^ q.pins.prev[irq_src_pkg::PIN_SERVO_VSYNC];

        ev[irq_src_pkg::SRC_PATTERN_GEN] = spg_eq & ~q.spg_eq_prev;
    end

    // level field of a write, 3 folds to the top level
    always_comb begin
        wr_level = i_reg_wdata[irq_src_pkg::CTRL_LEVEL_LSB +: irq_src_pkg::LEVEL_W];
        if (wr_level > irq_src_pkg::LEVEL_MAX) begin
            wr_level = irq_src_pkg::LEVEL_MAX;
        end
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        d = q;
        found = 1'b0;
        best_lvl = '0;
        best_src = '0;

        // pin synchronisers and history
        d.pins.s1   = {i_servo_vsync,
                       i_head_switch_signal,
                       i_control_signal, i_capstan_fg_input};
        d.pins.s2   = q.pins.s1;
        d.pins.prev = q.pins.s2;

        d.t6_prev   = i_timer6_count;
        d.spg_eq_prev = spg_eq;

        // register writes
        if (i_reg_wr) begin
            for (int i = 0; i < irq_src_pkg::NUM_SRC; i++) begin
                if (i_reg_addr == irq_src_pkg::ADDR_CTRL_BASE + 5'(i)) begin
                    d.ctrl[i].level  = wr_level;
                    d.ctrl[i].enable = i_reg_wdata[irq_src_pkg::CTRL_ENABLE_BIT];
                    // writing zero clears the pending flag, one keeps it
                    d.ctrl[i].pend   = q.ctrl[i].pend & i_reg_wdata[irq_src_pkg::CTRL_PEND_BIT];
                    if (i == irq_src_pkg::SRC_TIMER6) begin
                        d.ctrl[i].t6_sel = i_reg_wdata[irq_src_pkg::CTRL_T6SEL_LSB +: 2];
                    end
                end
            end

            unique case (i_reg_addr)
                irq_src_pkg::ADDR_STATUS: begin
                    d.status = q.status & ~i_reg_wdata[irq_src_pkg::NUM_SRC-1:0];
                end
                irq_src_pkg::ADDR_MASK: begin
                    d.mask = i_reg_wdata[irq_src_pkg::NUM_SRC-1:0];
                end
                irq_src_pkg::ADDR_PATTERN: begin
                    d.pattern = i_reg_wdata;
                end
                default: begin
                end
            endcase
        end

        // acceptance by the core clears the presented source
        if (i_irq_ack && q.irq_req) begin
            for (int i = 0; i < irq_src_pkg::NUM_SRC; i++) begin
                if (q.irq_src == 4'(i)) begin
                    d.ctrl[i].pend = 1'b0;
                end
            end
        end

        // events last, so a set beats any clear
        for (int i = 0; i < irq_src_pkg::NUM_SRC; i++) begin
            if (ev[i]) begin
                d.ctrl[i].pend = 1'b1;
                d.status[i]    = 1'b1;
            end
        end

        // pick the lowest level, lowest source on a tie
        for (int i = 0; i < irq_src_pkg::NUM_SRC; i++) begin
            if (d.ctrl[i].pend && d.ctrl[i].enable
                && (d.ctrl[i].level < i_psw_mask_level)) begin
                if (!found || (d.ctrl[i].level < best_lvl)) begin
                    found    = 1'b1;
                    best_lvl = d.ctrl[i].level;
                    best_src = 4'(i);
                end
            end
        end

        d.irq_req   = found;
        d.irq_level = best_lvl;
        d.irq_src   = best_src;
        d.int_out   = |(d.status & d.mask);

        // read data for the next cycle only
        d.rdata = '0;

        if (i_reg_rd) begin
            for (int i = 0; i < irq_src_pkg::NUM_SRC; i++) begin
                if (i_reg_addr == irq_src_pkg::ADDR_CTRL_BASE + 5'(i)) begin
                    d.rdata = 16'(q.ctrl[i]);
                end
            end

            unique case (i_reg_addr)
                irq_src_pkg::ADDR_STATUS: begin
                    d.rdata = 16'(q.status);
                end
                irq_src_pkg::ADDR_MASK: begin
                    d.rdata = 16'(q.mask);
                end
                irq_src_pkg::ADDR_PATTERN: begin
                    d.rdata = q.pattern;
                end
                irq_src_pkg::ADDR_PRESENT: begin
                    d.rdata = 16'({q.irq_req, q.irq_level, q.irq_src});
                end
                default: begin
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            q <= irq_src_pkg::STATE_RESET;
        end else begin
            q <= d;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign o_reg_rdata = q.rdata;
    assign o_irq_req   = q.irq_req;
    assign o_irq_level = q.irq_level;
    assign o_irq_src   = q.irq_src;
    assign o_int       = q.int_out;

    // ****************************************************************
    // checks
    // ****************************************************************
    logic [irq_src_pkg::ADDR_W-1:0]   ast_addr_q;
    logic [irq_src_pkg::LEVEL_W-1:0]  ast_psw_q;

    // helper copies of last cycle's inputs
    always_ff @(posedge i_sys_clk) begin
        ast_addr_q <= i_reg_addr;
        ast_psw_q  <= i_psw_mask_level;
    end

    default clocking ast_cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);

    AST_LEVEL_PRESENTED: assert property (
        o_irq_req
        |-> (o_irq_level == q.ctrl[o_irq_src].level) && q.ctrl[o_irq_src].pend)
        else $error("presented level differs from source control level");

    AST_LEVEL_STORED: assert property (
        (i_reg_wr && i_reg_addr < 5'h0B
         && !ev[i_reg_addr[3:0]])
        |=> (q.ctrl[ast_addr_q[3:0]].level == (($past(i_reg_wdata[1:0]) == 2'h3) ? 2'h2
                                               : $past(i_reg_wdata[1:0]))))
        else $error("written level not held");

    AST_CAPSTAN_EDGE: assert property (
        $rose(i_capstan_fg_input) ##1 1'b1 ##1 1'b1
        |=> q.ctrl[0].pend && q.status[0])
        else $error("capstan edge did not raise a request");

    AST_TIMER_OVF: assert property (
        (i_timer0_ovf || i_timer4_ovf)
        |=> ($past(i_timer0_ovf) -> q.ctrl[1].pend)
                                         && ($past(i_timer4_ovf) -> q.ctrl[5].pend))
        else $error("timer overflow did not raise its own request");

    AST_TIMER2_CAUSES: assert property (
        (i_timer2_cmp_match || i_timer2_capture_edge
         || i_serial_bit_down_counter_unf)
        |=> q.ctrl[3].pend && q.status[3])
        else $error("timer 2 cause lost");

    AST_TIMER6_SELECT: assert property (
        (q.ctrl[6].t6_sel == 2'h3 && q.t6_prev[12] && !i_timer6_count[12])
        |=> q.ctrl[6].pend)
        else $error("timer 6 count boundary missed");

    AST_CONTROL_CHANGE: assert property (
        (q.pins.s2[1] != q.pins.prev[1])
        |=> q.ctrl[7].pend)
        else $error("control signal change missed");

    AST_HEAD_SWITCH_CHANGE: assert property (
        $fell(q.pins.s2[2])
        |=> q.ctrl[8].pend && q.status[8])
        else $error("head switch change missed");

    AST_VSYNC_CHANGE: assert property (
        $changed(i_servo_vsync)
        ##1 $stable(i_servo_vsync)
        ##1 $stable(i_servo_vsync)
        |=> q.ctrl[9].pend)
        else $error("servo vsync change missed");

    AST_PATTERN_MATCH: assert property (
        (i_frc_value == q.pattern) && !q.spg_eq_prev
        |=> q.ctrl[10].pend)
        else $error("pattern timing match missed");

    AST_MASK_LEVEL: assert property (
        o_irq_req
        |-> (o_irq_level < ast_psw_q) && q.ctrl[o_irq_src].enable)
        else $error("request presented at or above the mask level");

    AST_PEND_HOLD: assert property (
        q.ctrl[0].pend && !i_reg_wr
        && !(i_irq_ack && o_irq_req && o_irq_src == 4'h0)
        |=> q.ctrl[0].pend)
        else $error("pending flag dropped without a clear");

    // acceptance, line, read port and level range
    AST_ACK_CLEARS: assert property (
        o_irq_req && i_irq_ack && !ev[o_irq_src]
        |=> !q.ctrl[$past(o_irq_src)].pend)
        else $error("accepted source still pending");

    AST_INT_LINE: assert property (
        o_int == ((q.status & q.mask) != 11'h000))
        else $error("interrupt line wrong");

    AST_RDATA_IDLE: assert property (
        !$past(i_reg_rd) |-> o_reg_rdata == 16'h0000)
        else $error("read data outside its cycle");

    AST_LEVEL_RANGE: assert property (
        o_irq_level <= irq_src_pkg::LEVEL_MAX)
        else $error("level above the top");

    // main scenarios
    COV_ACCEPT: cover property (
        o_irq_req && i_irq_ack);
    COV_TWO_PENDING: cover property (
        q.ctrl[1].pend && q.ctrl[7].pend && o_irq_req);
    COV_SET_AND_CLEAR: cover property (
        ev[1] && i_reg_wr && i_reg_addr == irq_src_pkg::ADDR_STATUS);
    COV_INT_OUT: cover property (
        $rose(o_int));

endmodule

`default_nettype wire

// ==== verif/cpu_core_model.sv ====
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// core side acceptance model
// ****************************************************************
module cpu_core_model (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_accept_en,
    input  wire logic [7:0] i_delay,
    input  wire logic [1:0] i_mask_level,
    input  wire logic       i_irq_req,
    input  wire logic [1:0] i_irq_level,
    input  wire logic [3:0] i_irq_src,
    output logic      [1:0] o_psw_mask_level,
    output logic            o_irq_ack,
    output logic      [3:0] o_first_src,
    output logic      [3:0] o_last_src,
    output logic      [7:0] o_accepted
);
    logic [7:0] wait_q;

    // mask level of the status word, held by the bench
    assign o_psw_mask_level = i_mask_level;

    // accept a presented request after a wait, never two acks in a row
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_irq_ack   <= 1'b0;
            wait_q      <= 8'h00;
            o_first_src <= 4'h0;
            o_last_src  <= 4'h0;
            o_accepted  <= 8'h00;
        end else begin
            o_irq_ack <= 1'b0;
            if (i_accept_en && i_irq_req && !o_irq_ack && (i_irq_level < i_mask_level)) begin
                if (wait_q >= i_delay) begin
                    o_irq_ack  <= 1'b1;
                    wait_q     <= 8'h00;
                    o_last_src <= i_irq_src;
                    o_accepted <= o_accepted + 8'h01;
                    if (o_accepted == 8'h00) begin
                        o_first_src <= i_irq_src;
                    end
                end else begin
                    wait_q <= wait_q + 8'h01;
                end
            end
        end
    end
endmodule

`default_nettype wire

// ==== verif/maskable_interrupt_request_sources_tb.sv ====
`timescale 1ns/100ps
`default_nettype none

module maskable_interrupt_request_sources_tb;
    logic        i_sys_clk;
    logic        i_rst_n;
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic        wr_s;
    logic        rd_s;
    logic [15:0] o_reg_rdata;
    logic [3:0]  pins;
    logic [7:0]  pulse;
    logic [15:0] t6;
    logic [15:0] frc;
    logic [1:0]  mask_lvl;
    logic [1:0]  processor_status_word;
    logic        ack;
    logic        accept_en;
    logic [7:0]  delay;
    logic        o_irq_req;
    logic [1:0]  o_irq_level;
    logic [3:0]  o_irq_src;
    logic        o_int;
    logic [3:0]  first_src;
    logic [3:0]  last_src;
    logic [7:0]  accepted;
    int          errors;
    int          total_checks;
    int          cycles;
    int          src_tab [8] = '{1, 2, 3, 3, 3, 3, 4, 5};
    int          pin_src [4] = '{0, 7, 8, 9};

    maskable_irq_sources DUT (
        .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .i_reg_wr(wr_s), .i_reg_rd(rd_s), .o_reg_rdata(o_reg_rdata),
        .i_capstan_fg_input(pins[0]), .i_control_signal(pins[1]),
        .i_head_switch_signal(pins[2]), .i_servo_vsync(pins[3]),
        .i_timer0_ovf(pulse[0]), .i_timer1_ovf(pulse[1]), .i_timer2_ovf(pulse[2]),
        .i_timer2_cmp_match(pulse[3]), .i_timer2_capture_edge(pulse[4]),
        .i_serial_bit_down_counter_unf(pulse[5]), .i_timer3_ovf(pulse[6]), .i_timer4_ovf(pulse[7]),
        .i_timer6_count(t6), .i_frc_value(frc), .i_psw_mask_level(processor_status_word), .i_irq_ack(ack),
        .o_irq_req(o_irq_req), .o_irq_level(o_irq_level), .o_irq_src(o_irq_src), .o_int(o_int));

    cpu_core_model core (
        .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_accept_en(accept_en), .i_delay(delay),
        .i_mask_level(mask_lvl), .i_irq_req(o_irq_req), .i_irq_level(o_irq_level),
        .i_irq_src(o_irq_src), .o_psw_mask_level(processor_status_word), .o_irq_ack(ack),
        .o_first_src(first_src), .o_last_src(last_src), .o_accepted(accepted));

    // ****************************************************************
    // clock and hang guard
    // ****************************************************************
    initial begin
        i_sys_clk = 1'b0;
        forever #50 i_sys_clk = ~i_sys_clk;
    end

    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            end_sim();
        end
    end

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge i_sys_clk);
        addr  <= a;
        wdata <= d;
        wr_s  <= 1'b1;
        @(posedge i_sys_clk);
        wr_s  <= 1'b0;
    endtask

    task automatic rdchk(input logic [4:0] a, input logic [15:0] exp);
        @(posedge i_sys_clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge i_sys_clk);
        rd_s <= 1'b0;
        #1;
        chk(o_reg_rdata, exp);
    endtask

    // status and pending seen, then both cleared by software
    task automatic expect_event(input int src, input logic [15:0] ctrl);
        rdchk(irq_src_pkg::ADDR_STATUS, 16'(1 << src));
        rdchk(5'(src), ctrl);
        wr(irq_src_pkg::ADDR_STATUS, 16'h07FF);
        wr(5'(src), ctrl & 16'hFFF7);
        rdchk(5'(src), ctrl & 16'hFFF7);
        rdchk(irq_src_pkg::ADDR_STATUS, 16'h0000);
    endtask

    task automatic fire(input logic [7:0] p);
        @(posedge i_sys_clk) pulse <= p;
        @(posedge i_sys_clk) pulse <= 8'h00;
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        {addr, wdata, wr_s, rd_s, pins, pulse, t6, accept_en} = '0;
        {errors, total_checks, cycles} = '0;
        frc      = 16'h0001;
        mask_lvl = 2'h0;
        delay    = 8'h05;
        i_rst_n  = 1'b0;
        repeat (6) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        // reset values, unmapped and read-only places
        for (int i = 0; i < 11; i++) rdchk(5'(i), 16'h0000);
        rdchk(irq_src_pkg::ADDR_STATUS, 16'h0000);
        rdchk(irq_src_pkg::ADDR_MASK, 16'h0000);
        rdchk(irq_src_pkg::ADDR_PATTERN, 16'h0000);
        wr(5'h1F, 16'hFFFF);
        rdchk(5'h1F, 16'h0000);
        wr(irq_src_pkg::ADDR_PRESENT, 16'hFFFF);
        rdchk(irq_src_pkg::ADDR_PRESENT, 16'h0000);
        $display("test reset done");
        // every level on every source, 3 stored as 2
        for (int l = 0; l < 4; l++) begin
            for (int i = 0; i < 11; i++) begin
                wr(5'(i), 16'(4 + l));
                rdchk(5'(i), 16'(4 + ((l > 2) ? 2 : l)));
            end
        end
        for (int i = 0; i < 11; i++) wr(5'(i), 16'h0000);
        $display("test levels done");
        // same-clock timer causes
        for (int k = 0; k < 8; k++) begin
            fire(8'h01 << k);
            expect_event(src_tab[k], 16'h0008);
        end
        $display("test timers done");
        // pins: capstan on rising only, others on either edge
        for (int p = 0; p < 4; p++) begin
            @(posedge i_sys_clk) pins[p] <= 1'b1;
            repeat (5) @(posedge i_sys_clk);
            expect_event(pin_src[p], 16'h0008);
            @(posedge i_sys_clk) pins[p] <= 1'b0;
            repeat (5) @(posedge i_sys_clk);
            if (p == 0) rdchk(irq_src_pkg::ADDR_STATUS, 16'h0000);
            else expect_event(pin_src[p], 16'h0008);
        end
        $display("test pins done");
        // timer 6 cause select, a wrong bit must stay quiet
        for (int s = 0; s < 4; s++) begin
            wr(5'(irq_src_pkg::SRC_TIMER6), 16'(s << 4));
            if (s > 0) begin
                @(posedge i_sys_clk) t6 <= 16'h8000;
                @(posedge i_sys_clk) t6 <= 16'h0000;
                rdchk(irq_src_pkg::ADDR_STATUS, 16'h0000);
            end
            @(posedge i_sys_clk) t6 <= 16'((17'h1 << (16 - s)) - 17'h1);
            @(posedge i_sys_clk) t6 <= 16'h0000;
            expect_event(irq_src_pkg::SRC_TIMER6, 16'((s << 4) + 8));
        end
        $display("test timer6 done");
        // pattern timing match
        wr(irq_src_pkg::ADDR_PATTERN, 16'h1234);
        rdchk(irq_src_pkg::ADDR_PATTERN, 16'h1234);
        @(posedge i_sys_clk) frc <= 16'h1233;
        rdchk(irq_src_pkg::ADDR_STATUS, 16'h0000);
        @(posedge i_sys_clk) frc <= 16'h1234;
        expect_event(irq_src_pkg::SRC_PATTERN_GEN, 16'h0008);
        $display("test pattern done");
        // presentation by level, mask level and enable
        wr(5'h01, 16'h0006);
        wr(5'h02, 16'h0005);
        @(posedge i_sys_clk) mask_lvl <= 2'h1;
        fire(8'h07);
        repeat (3) @(posedge i_sys_clk);
        #1 chk(16'(o_irq_req), 16'h0000);
        @(posedge i_sys_clk) mask_lvl <= 2'h3;
        repeat (3) @(posedge i_sys_clk);
        #1 chk(16'(o_irq_level), 16'h0001);
        chk(16'(o_irq_src), 16'h0002);
        rdchk(irq_src_pkg::ADDR_PRESENT, 16'h0052);
        repeat (20) @(posedge i_sys_clk);
        #1 chk(16'(o_irq_req), 16'h0001);
        @(posedge i_sys_clk) accept_en <= 1'b1;
        for (int n = 0; n < 100 && accepted !== 8'h02; n++) @(posedge i_sys_clk);
        #1 chk(16'(first_src), 16'h0002);
        chk(16'(last_src), 16'h0001);
        repeat (2) @(posedge i_sys_clk);
        #1 chk(16'(o_irq_req), 16'h0000);
        rdchk(5'h03, 16'h0008);
        accept_en <= 1'b0;
        $display("test presentation done");
        // interrupt line follows status and mask
        wr(irq_src_pkg::ADDR_STATUS, 16'h07FF);
        wr(irq_src_pkg::ADDR_MASK, 16'h0002);
        fire(8'h01);
        repeat (2) @(posedge i_sys_clk);
        #1 chk(16'(o_int), 16'h0001);
        wr(irq_src_pkg::ADDR_STATUS, 16'h0002);
        repeat (2) @(posedge i_sys_clk);
        #1 chk(16'(o_int), 16'h0000);
        wr(irq_src_pkg::ADDR_MASK, 16'h0000);
        fire(8'h01);
        repeat (2) @(posedge i_sys_clk);
        #1 chk(16'(o_int), 16'h0000);
        rdchk(irq_src_pkg::ADDR_STATUS, 16'h0002);
        $display("test interrupt line done");
        end_sim();
    end
endmodule

`default_nettype wire
